// >>> tag_calc_pkg.sv
// Package with the register map, field positions and arithmetic constants of the tag computation block.
package tag_calc_pkg;

    localparam int NUM_BINS = 16;

    // -------------------------------------------------------------------
    // Register word indexes (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [9:0] IDX_CONTROL = 10'h00A;
    localparam logic [9:0] IDX_BIN_ENABLE = 10'h010;
    localparam logic [9:0] IDX_SAMPLE_STORE = 10'h011;
    localparam logic [9:0] IDX_INTERVAL0 = 10'h023;
    localparam logic [9:0] IDX_THRESHOLD0 = 10'h033;
    localparam logic [9:0] IDX_ENERGY_L = 10'h043;
    localparam logic [9:0] IDX_ENERGY_H = 10'h044;
    localparam logic [9:0] IDX_KIN_THR = 10'h045;
    localparam logic [9:0] IDX_REF_TEMP = 10'h046;
    localparam logic [9:0] IDX_Q10_L = 10'h047;
    localparam logic [9:0] IDX_Q10_H = 10'h048;
    localparam logic [9:0] IDX_REF_TIME = 10'h049;
    localparam logic [9:0] IDX_SHELF_THR = 10'h04A;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h04B;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h04C;
    localparam logic [9:0] IDX_STATUS = 10'h051;
    localparam logic [9:0] IDX_KIN_VAL = 10'h052;
    localparam logic [9:0] IDX_SHELF_L = 10'h053;
    localparam logic [9:0] IDX_SHELF_H = 10'h054;
    localparam logic [9:0] IDX_BIN_ALARM = 10'h055;
    localparam logic [9:0] IDX_COUNT0 = 10'h056;
    localparam logic [9:0] IDX_SAMPLES = 10'h067;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int CTRL_RST = 0;
    localparam int CTRL_KINETIC_CALC_ENABLE = 6;
    localparam int CTRL_SHELF_LIFE_CALC_ENABLE = 7;
    localparam int ST_KIN = 0;
    localparam int ST_SHELF = 1;
    localparam int ST_BIN = 2;
    localparam int ST_BAT0 = 3;
    localparam int ST_BAT1 = 4;
    localparam int ST_SLEEP = 5;
    localparam int ST_BUSY = 6;
    localparam int EV_KIN = 0;
    localparam int EV_SHELF = 1;
    localparam int EV_BIN = 2;
    localparam int EV_BAT = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0010;
    localparam logic [15:0] BIN_EN_RESET = 16'h0001;
    localparam logic [15:0] STORE_RESET = 16'hFFFF;
    localparam logic [15:0] INTERVAL0_RESET = 16'h0258;
    localparam logic [15:0] THRESH_OFF = 16'hFFFF;
    localparam logic [1:0] BAT_LOW = 2'h1;

    // -------------------------------------------------------------------
    // Arithmetic constants
    // -------------------------------------------------------------------
    localparam logic [31:0] KELVIN_OFS = 32'h0000_0111;
    localparam logic [31:0] TMAX_K = 32'h0000_0157;
    localparam logic [47:0] LOG2E_OVER_R_Q16 = 48'h0000_0000_2C6C;
    localparam logic [31:0] W_ONE = 32'h0001_0000;
    localparam logic [47:0] HOUR_Q8 = 48'h0000_000E_1000;

    typedef struct packed {
        logic signed [15:0] temp;
        logic [3:0] bin;
    } sample_t;

    typedef enum logic [2:0] {
        CS_IDLE = 3'b000,
        CS_DIV_X = 3'b001,
        CS_DIV_X0 = 3'b010,
        CS_DIV_MEAN = 3'b011,
        CS_DIV_MKT = 3'b100,
        CS_SHELF = 3'b101,
        CS_HOURS = 3'b110
    } calc_state_t;

endpackage : tag_calc_pkg

// >>> div_serial.sv
// Restoring serial divider, one quotient bit per clock.
`timescale 1ns/100ps
module div_serial #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] num_i,
    input wire logic [W-1:0] den_i,
    output logic done_o,
    output logic [W-1:0] quot_o
);
    localparam int CW = $clog2(W + 1);

    logic [W-1:0] rem;
    logic [W-1:0] den;
    logic [CW-1:0] cnt;
    logic [W:0] shifted;
    logic [W:0] diff;

    assign shifted = {rem, quot_o[W-1]};
    assign diff = shifted - {1'b0, den};

    // A zero divisor gives an all-ones quotient.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rem <= '0;
            den <= '0;
            cnt <= '0;
            quot_o <= '0;
            done_o <= 1'b0;
        end
        else if (start_i)
        begin
            rem <= '0;
            den <= den_i;
            quot_o <= num_i;
            cnt <= CW'(W);
            done_o <= 1'b0;
        end
        else if (cnt != '0)
        begin
            rem <= diff[W] ? shifted[W-1:0] : diff[W-1:0];
            quot_o <= {quot_o[W-2:0], ~diff[W]};
            cnt <= cnt - 1'b1;
            done_o <= (cnt == CW'(1));
        end
        else
        begin
            done_o <= 1'b0;
        end
    end

endmodule : div_serial

// >>> tag_calc.sv
// Per-sample kinetic temperature, shelf life, bin alarm and battery logic with APB registers.
`timescale 1ns/100ps
module tag_calc (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sample_valid_i,
    input wire tag_calc_pkg::sample_t sample_i,
    output logic sample_ready_o,
    input wire logic [1:0] battery_level_i,
    output logic log_write_o,
    output logic log_erase_o,
    output logic force_sleep_o,
    output logic battery_critical_o,
    output logic irq_o
);
    import tag_calc_pkg::*;

    logic [15:0] control, bin_enable, store_enable, kin_thr, ref_temp;
    logic [15:0] q10_l, q10_h, ref_time, shelf_thr, irq_mask, energy_l, energy_h;
    logic [15:0] bin_interval [NUM_BINS];
    logic [15:0] bin_threshold [NUM_BINS];
    logic [15:0] bin_count [NUM_BINS];
    logic [NUM_BINS-1:0] bin_alarm, bin_alarm_d;
    logic [3:0] irq_stat, events;
    logic [1:0] bat_meta, battery;
    logic crit_d, kin_alarm, shelf_alarm, mkt_over, sleep;
    logic [15:0] kinetic_value, samples_num;
    logic [31:0] shelf_remaining, hours_used, sum_w, x_val, x_ref, next_remaining;
    logic [47:0] acc, k_prod;
    logic [31:0] k_num, t_kelvin, div_num, div_den, div_q;
    logic signed [31:0] delta_t;
    logic signed [47:0] e_prod;
    sample_t cur;
    calc_state_t state;
    logic div_go, div_done, accept, wr_en, rd_acc, erase;
    logic [9:0] idx;

    // -------------------------------------------------------------------
    // Helper functions
    // -------------------------------------------------------------------
    function automatic logic in_bank(input logic [9:0] a, input logic [9:0] base);
        return (a >= base) && (a < base + 10'(NUM_BINS));
    endfunction : in_bank

    // Weight 2^-d for a Q8 exponent d, result in Q16, linear in the fraction.
    function automatic logic [31:0] weight(input logic [31:0] d);
        if (|d[31:13])
            return 32'h0;
        return (W_ONE - 32'({d[7:0], 7'h00})) >> d[12:8];
    endfunction : weight

    // Minus log2 of a Q16 mean, returned in Q8.
    function automatic logic [31:0] neg_log2(input logic [31:0] m);
        int p;
        logic [31:0] norm;
        int l;
        p = 0;
        for (int i = 0; i < 32; i++)
            if (m[i])
                p = i;
        norm = m << (31 - p);
        l = (16 - p) * 256 - int'(norm[30:23]);
        if (m == 32'h0)
            l = 32 * 256;
        return (l < 0) ? 32'h0 : 32'(l);
    endfunction : neg_log2

    // Two to the power of a signed Q8 exponent, result in Q8.
    function automatic logic [31:0] pow2_q8(input logic signed [31:0] e);
        logic [31:0] base;
        logic signed [31:0] ip;
        base = 32'h100 + 32'(e[7:0]);
        ip = e >>> 8;
        if (ip >= 15)
            return base << 15;
        if (ip >= 0)
            return base << ip[3:0];
        if (ip <= -16)
            return 32'h0;
        return base >> 4'(-ip);
    endfunction : pow2_q8

    // -------------------------------------------------------------------
    // APB slave
    // -------------------------------------------------------------------
    assign idx = paddr_i[11:2];
    assign wr_en = psel_i & penable_i & pwrite_i;
    assign rd_acc = psel_i & penable_i & ~pwrite_i;
    assign erase = wr_en && idx == IDX_CONTROL && pwdata_i[CTRL_RST];
    assign pready_o = 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            control <= CTRL_RESET;
            bin_enable <= BIN_EN_RESET;
            store_enable <= STORE_RESET;
            {kin_thr, ref_temp, q10_l, q10_h, ref_time} <= '0;
            {shelf_thr, irq_mask, energy_l, energy_h} <= '0;
        end
        else if (wr_en)
        begin
            case (idx)
                IDX_CONTROL: control <= pwdata_i[15:0] & ~(16'h1 << CTRL_RST);
                IDX_BIN_ENABLE: bin_enable <= pwdata_i[15:0];
                IDX_SAMPLE_STORE: store_enable <= pwdata_i[15:0];
                IDX_ENERGY_L: energy_l <= pwdata_i[15:0];
                IDX_ENERGY_H: energy_h <= pwdata_i[15:0];
                IDX_KIN_THR: kin_thr <= pwdata_i[15:0];
                IDX_REF_TEMP: ref_temp <= pwdata_i[15:0];
                IDX_Q10_L: q10_l <= pwdata_i[15:0];
                IDX_Q10_H: q10_h <= pwdata_i[15:0];
                IDX_REF_TIME: ref_time <= pwdata_i[15:0];
                IDX_SHELF_THR: shelf_thr <= pwdata_i[15:0];
                IDX_IRQ_MASK: irq_mask <= pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // Read data is captured in the setup cycle so it is stable in the access cycle.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prdata_o <= '0;
            pslverr_o <= 1'b0;
        end
        else if (psel_i && !penable_i)
        begin
            pslverr_o <= 1'b0;
            prdata_o <= '0;
            if (in_bank(idx, IDX_INTERVAL0))
                prdata_o[15:0] <= bin_interval[4'(idx - IDX_INTERVAL0)];
            else if (in_bank(idx, IDX_THRESHOLD0))
                prdata_o[15:0] <= bin_threshold[4'(idx - IDX_THRESHOLD0)];
            else if (in_bank(idx, IDX_COUNT0))
                prdata_o[15:0] <= bin_count[4'(idx - IDX_COUNT0)];
            else
                case (idx)
                    IDX_CONTROL: prdata_o[15:0] <= control;
                    IDX_BIN_ENABLE: prdata_o[15:0] <= bin_enable;
                    IDX_SAMPLE_STORE: prdata_o[15:0] <= store_enable;
                    IDX_ENERGY_L: prdata_o[15:0] <= energy_l;
                    IDX_ENERGY_H: prdata_o[15:0] <= energy_h;
                    IDX_KIN_THR: prdata_o[15:0] <= kin_thr;
                    IDX_REF_TEMP: prdata_o[15:0] <= ref_temp;
                    IDX_Q10_L: prdata_o[15:0] <= q10_l;
                    IDX_Q10_H: prdata_o[15:0] <= q10_h;
                    IDX_REF_TIME: prdata_o[15:0] <= ref_time;
                    IDX_SHELF_THR: prdata_o[15:0] <= shelf_thr;
                    IDX_IRQ_MASK: prdata_o[15:0] <= irq_mask;
                    IDX_IRQ_STAT: prdata_o[3:0] <= irq_stat;
                    IDX_STATUS: prdata_o[6:0] <= {state != CS_IDLE, sleep, battery,
                        |bin_alarm, shelf_alarm, kin_alarm};
                    IDX_KIN_VAL: prdata_o[15:0] <= kinetic_value;
                    IDX_SHELF_L: prdata_o[15:0] <= shelf_remaining[15:0];
                    IDX_SHELF_H: prdata_o[15:0] <= shelf_remaining[31:16];
                    IDX_BIN_ALARM: prdata_o[15:0] <= bin_alarm;
                    IDX_SAMPLES: prdata_o[15:0] <= samples_num;
                    default: pslverr_o <= 1'b1;
                endcase
        end
    end

    // -------------------------------------------------------------------
    // Battery level and sleep
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            bat_meta <= 2'h3;
            battery <= 2'h3;
            crit_d <= 1'b0;
        end
        else
        begin
            bat_meta <= battery_level_i;
            battery <= bat_meta;
            crit_d <= sleep;
        end
    end

    assign sleep = battery <= BAT_LOW;
    assign force_sleep_o = sleep;
    assign battery_critical_o = sleep;

    // -------------------------------------------------------------------
    // Histogram bins
    // -------------------------------------------------------------------
    assign accept = sample_valid_i & sample_ready_o;
    assign sample_ready_o = (state == CS_IDLE) & ~sleep;

    for (genvar g = 0; g < NUM_BINS; g++)
    begin : g_bin
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                bin_interval[g] <= (g == 0) ? INTERVAL0_RESET : 16'h0;
                bin_threshold[g] <= THRESH_OFF;
            end
            else if (wr_en && idx == IDX_INTERVAL0 + 10'(g))
                bin_interval[g] <= pwdata_i[15:0];
            else if (wr_en && idx == IDX_THRESHOLD0 + 10'(g))
                bin_threshold[g] <= pwdata_i[15:0];
        end

        always_ff @(posedge clk_i)
        begin
            if (rst_i || erase)
                bin_count[g] <= '0;
            else if (accept && sample_i.bin == 4'(g) && bin_enable[g] && bin_count[g] != 16'hFFFF)
                bin_count[g] <= bin_count[g] + 16'h1;
        end

        assign bin_alarm[g] = bin_enable[g] && bin_threshold[g] != THRESH_OFF
            && bin_count[g] >= bin_threshold[g];
    end

    // Log writes are blocked in Sleep so the stored log stays intact.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            log_write_o <= 1'b0;
            log_erase_o <= 1'b0;
        end
        else
        begin
            log_write_o <= accept && bin_enable[sample_i.bin] && store_enable[sample_i.bin];
            log_erase_o <= erase;
        end
    end

    // -------------------------------------------------------------------
    // Calculation sequencer
    // -------------------------------------------------------------------
    assign k_prod = {16'h0, energy_h, energy_l} * LOG2E_OVER_R_Q16;
    assign k_num = {k_prod[39:16], 8'h00};
    assign t_kelvin = 32'(signed'(cur.temp)) + KELVIN_OFS;
    assign mkt_over = signed'(16'(div_q - KELVIN_OFS)) > signed'(kin_thr);
    assign delta_t = 32'(signed'(cur.temp)) - 32'(signed'(ref_temp));
    assign e_prod = 48'(delta_t) * signed'({16'h0, q10_h, q10_l});
    assign next_remaining = (32'(ref_time) > hours_used) ? 32'(ref_time) - hours_used : 32'h0;

    always_comb
    begin
        div_num = k_num;
        div_den = t_kelvin;
        case (state)
            CS_DIV_X0: div_den = TMAX_K;
            CS_DIV_MEAN:
            begin
                div_num = sum_w;
                div_den = 32'(samples_num);
            end
            CS_DIV_MKT: div_den = x_ref + neg_log2(div_q);
            default: ;
        endcase
    end

    div_serial #(.W(32)) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(div_go),
        .num_i(div_num),
        .den_i(div_den),
        .done_o(div_done),
        .quot_o(div_q)
    );

    always_ff @(posedge clk_i)
    begin
        if (rst_i || erase)
        begin
            state <= CS_IDLE;
            div_go <= 1'b0;
            {cur, x_val, x_ref, sum_w, acc, hours_used} <= '0;
            {samples_num, kinetic_value, kin_alarm, shelf_alarm} <= '0;
            shelf_remaining <= '0;
        end
        else
        begin
            div_go <= 1'b0;
            case (state)
                CS_IDLE:
                    if (accept)
                    begin
                        cur <= sample_i;
                        if (control[CTRL_KINETIC_CALC_ENABLE])
                        begin
                            samples_num <= samples_num + 16'h1;
                            state <= CS_DIV_X;
                            div_go <= 1'b1;
                        end
                        else
                            state <= CS_SHELF;
                    end
                CS_DIV_X:
                    if (div_done)
                    begin
                        x_val <= div_q;
                        state <= CS_DIV_X0;
                        div_go <= 1'b1;
                    end
                CS_DIV_X0:
                    if (div_done)
                    begin
                        x_ref <= div_q;
                        sum_w <= sum_w + weight((x_val > div_q) ? x_val - div_q : 32'h0);
                        state <= CS_DIV_MEAN;
                        div_go <= 1'b1;
                    end
                CS_DIV_MEAN:
                    if (div_done)
                    begin
                        state <= CS_DIV_MKT;
                        div_go <= 1'b1;
                    end
                CS_DIV_MKT:
                    if (div_done)
                    begin
                        kinetic_value <= 16'(div_q - KELVIN_OFS);
                        kin_alarm <= kin_alarm | mkt_over;
                        state <= CS_SHELF;
                    end
                CS_SHELF:
                    if (control[CTRL_SHELF_LIFE_CALC_ENABLE])
                    begin
                        acc <= acc + 48'(pow2_q8(e_prod[39:8])) * 48'(bin_interval[cur.bin]);
                        state <= CS_HOURS;
                    end
                    else
                        state <= CS_IDLE;
                CS_HOURS:
                    if (acc >= HOUR_Q8)
                    begin
                        acc <= acc - HOUR_Q8;
                        hours_used <= hours_used + 32'h1;
                    end
                    else
                    begin
                        shelf_remaining <= next_remaining;
                        shelf_alarm <= shelf_alarm | (next_remaining < 32'(shelf_thr));
                        state <= CS_IDLE;
                    end
                default: state <= CS_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Interrupts
    // -------------------------------------------------------------------
    always_comb
    begin
        events = '0;
        events[EV_KIN] = state == CS_DIV_MKT && div_done && mkt_over && !kin_alarm;
        events[EV_SHELF] = state == CS_HOURS && acc < HOUR_Q8 && !shelf_alarm
            && next_remaining < 32'(shelf_thr);
        events[EV_BIN] = |(bin_alarm & ~bin_alarm_d);
        events[EV_BAT] = sleep & ~crit_d;
    end

    // A new event in the clearing read's cycle survives the clear.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat <= '0;
            bin_alarm_d <= '0;
            irq_o <= 1'b0;
        end
        else
        begin
            bin_alarm_d <= bin_alarm;
            irq_stat <= ((rd_acc && idx == IDX_IRQ_STAT) ? 4'h0 : irq_stat) | events;
            irq_o <= |(irq_stat & irq_mask[3:0]);
        end
    end

endmodule : tag_calc

// >>> tag_calc_checker.sv
// Port-level assertions for the tag computation block.
`timescale 1ns/100ps
module tag_calc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic sample_valid_i,
    input wire logic sample_ready_o,
    input wire logic [1:0] battery_level_i,
    input wire logic log_write_o,
    input wire logic log_erase_o,
    input wire logic force_sleep_o,
    input wire logic battery_critical_o
);
    import tag_calc_pkg::*;
    logic erase_req;
    assign erase_req = psel_i && penable_i && pwrite_i && paddr_i[11:2] == IDX_CONTROL
        && pwdata_i[CTRL_RST];
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    chk_crit_sleep: assert property (battery_critical_o == force_sleep_o)
        else $error("Critical output differs from sleep.");
    chk_sleep_stall: assert property (force_sleep_o |-> !sample_ready_o)
        else $error("Ready while sleeping.");
    chk_low_sleeps: assert property ((battery_level_i <= BAT_LOW) [*3] |=> force_sleep_o)
        else $error("Low battery without sleep.");
    chk_ok_awake: assert property ((battery_level_i > BAT_LOW) [*3] |=> !force_sleep_o)
        else $error("Sleep at good battery.");
    chk_erase_due: assert property (erase_req |=> log_erase_o)
        else $error("Erase command without pulse.");
    chk_erase_cause: assert property (log_erase_o |-> $past(erase_req))
        else $error("Erase pulse without command.");
    chk_log_cause: assert property (log_write_o |-> $past(sample_valid_i && sample_ready_o))
        else $error("Log write without sample.");
    chk_busy_after: assert property (sample_valid_i && sample_ready_o |=> !sample_ready_o)
        else $error("No calculation after sample.");
endmodule : tag_calc_checker

bind tag_calc tag_calc_checker u_checker (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
    .battery_level_i(battery_level_i), .log_write_o(log_write_o), .log_erase_o(log_erase_o),
    .force_sleep_o(force_sleep_o), .battery_critical_o(battery_critical_o));

// >>> tb_tag_calc.sv
// Self-checking testbench of the tag computation block.
`timescale 1ns/100ps
module tb_tag_calc;
    import tag_calc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic sample_valid_i = 1'b0;
    sample_t sample_i = '0;
    logic [1:0] battery_level_i = 2'h3;
    logic [31:0] prdata_o, q;
    logic pready_o, pslverr_o, sample_ready_o, log_write_o, log_erase_o;
    logic force_sleep_o, battery_critical_o, irq_o, lw, perr;
    int err_count = 0;
    int total_checks = 0;
    always #10 clk_i = ~clk_i;
    tag_calc u_dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i),
        .sample_i(sample_i), .sample_ready_o(sample_ready_o), .log_write_o(log_write_o),
        .battery_level_i(battery_level_i), .log_erase_o(log_erase_o), .irq_o(irq_o),
        .force_sleep_o(force_sleep_o), .battery_critical_o(battery_critical_o));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {idx, 2'b00};
        pwdata_i <= {16'h0000, d};
        @(posedge clk_i);
        penable_i <= 1'b1;
        @(posedge clk_i);
        while (pready_o !== 1'b1)
            @(posedge clk_i);
        q = prdata_o;
        perr = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask : apb
    task automatic rc(input string n, input logic [9:0] i, input logic [31:0] m, e);
        apb(1'b0, i, 16'h0000);
        chk(n, e, q & m);
    endtask : rc
    task automatic smp(input logic signed [15:0] t);
        sample_i <= '{temp: t, bin: 4'h0};
        sample_valid_i <= 1'b1;
        @(negedge clk_i);
        while (sample_ready_o !== 1'b1)
            @(negedge clk_i);
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        @(negedge clk_i);
        lw = log_write_o;
        while (sample_ready_o !== 1'b1)
            @(negedge clk_i);
        @(posedge clk_i);
    endtask : smp
    initial
    begin
        #400000;
        err_count++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rc("ctrl", IDX_CONTROL, 32'hFFFF, 32'h0010);
        apb(1'b0, 10'h04D, 16'h0000);
        chk("slverr", 32'h1, {31'h0, perr});
        smp(16'sd0);
        chk("log_on", 32'h1, {31'h0, lw});
        rc("bin_alarm", IDX_BIN_ALARM, 32'h1, 32'h0);
        apb(1'b1, IDX_THRESHOLD0, 16'h0002);
        apb(1'b1, IDX_IRQ_MASK, 16'h0004);
        rc("bin_alarm", IDX_BIN_ALARM, 32'h1, 32'h0);
        smp(16'sd0);
        rc("bin_alarm", IDX_BIN_ALARM, 32'h1, 32'h1);
        chk("irq", 32'h1, {31'h0, irq_o});
        rc("irq_stat", IDX_IRQ_STAT, 32'hF, 32'h4);
        @(negedge clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        apb(1'b1, IDX_SAMPLE_STORE, 16'hFFFE);
        smp(16'sd0);
        chk("log_off", 32'h0, {31'h0, lw});
        apb(1'b1, IDX_ENERGY_L, 16'h44C8);
        apb(1'b1, IDX_ENERGY_H, 16'h0001);
        apb(1'b1, IDX_KIN_THR, 16'h0028);
        apb(1'b1, IDX_CONTROL, 16'h0050);
        smp(16'sd25);
        smp(16'sd25);
        rc("samples", IDX_SAMPLES, 32'hFFFF, 32'h2);
        rc("kin_alarm", IDX_STATUS, 32'h1, 32'h0);
        apb(1'b1, IDX_KIN_THR, 16'h0014);
        smp(16'sd25);
        rc("kin_alarm", IDX_STATUS, 32'h1, 32'h1);
        apb(1'b1, IDX_CONTROL, 16'h0010);
        smp(16'sd60);
        rc("samples", IDX_SAMPLES, 32'hFFFF, 32'h3);
        apb(1'b0, IDX_KIN_VAL, 16'h0000);
        chk("kin_val", 32'h1, {31'h0, q >= 32'd22 && q <= 32'd28});
        apb(1'b1, IDX_INTERVAL0, 16'h0E10);
        apb(1'b1, IDX_REF_TEMP, 16'h0019);
        apb(1'b1, IDX_Q10_L, 16'h1999);
        apb(1'b1, IDX_REF_TIME, 16'h0064);
        apb(1'b1, IDX_SHELF_THR, 16'h0063);
        apb(1'b1, IDX_CONTROL, 16'h0090);
        smp(16'sd25);
        rc("shelf", IDX_SHELF_L, 32'hFFFF, 32'd99);
        rc("shelf_alarm", IDX_STATUS, 32'h2, 32'h0);
        smp(16'sd25);
        rc("shelf", IDX_SHELF_L, 32'hFFFF, 32'd98);
        rc("shelf_alarm", IDX_STATUS, 32'h2, 32'h2);
        chk("irq_masked", 32'h0, {31'h0, irq_o});
        rc("irq_stat", IDX_IRQ_STAT, 32'hF, 32'h3);
        apb(1'b1, IDX_CONTROL, 16'h0010);
        smp(16'sd40);
        rc("shelf", IDX_SHELF_L, 32'hFFFF, 32'd98);
        apb(1'b1, IDX_CONTROL, 16'h0011);
        rc("count0", IDX_COUNT0, 32'hFFFF, 32'h0);
        for (int l = 3; l >= 0; l--)
        begin
            battery_level_i <= 2'(l);
            repeat (4) @(posedge clk_i);
            rc("battery", IDX_STATUS, 32'h18, 32'(l) << 3);
            chk("sleep", 32'(l <= 1), {31'h0, force_sleep_o});
        end
        rc("irq_stat", IDX_IRQ_STAT, 32'hF, 32'h8);
        end_sim();
    end
endmodule : tb_tag_calc
